// [nfh_map.vh]
/*
 * constants for the parallel nor flash host controller: command codes,
 * unlock addresses, operation codes and bus timing counts.
 * assumes a 50 MHz ref_clk; times are kept in ns and turned into cycles.
 */
`ifndef NFH_MAP_VH
`define NFH_MAP_VH

// clock period in ns
`define NFH_CLK_NS 20
// access time of the device, ns, and read sampling count (round up)
`define NFH_T_ACC_NS 70
`define NFH_ACC_CYC ((`NFH_T_ACC_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
// strobe low time and setup/hold per write phase, ns (least times, round up)
`define NFH_T_WP_NS 40
`define NFH_WP_CYC ((`NFH_T_WP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_T_WH_NS 20
`define NFH_WH_CYC ((`NFH_T_WH_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)

// command data bytes
`define NFH_D_UNLOCK1 8'hAA
`define NFH_D_UNLOCK2 8'h55
`define NFH_D_AUTOSEL 8'h90
`define NFH_D_PROGRAM 8'hA0
`define NFH_D_BYPASS 8'h20
`define NFH_D_RESET 8'hF0
`define NFH_D_BYP_EXIT 8'h00
`define NFH_D_SUSPEND 8'hB0
`define NFH_D_RESUME 8'h30
`define NFH_D_QUERY 8'h98

// unlock addresses, word and byte mode
`define NFH_A_W1 12'h555
`define NFH_A_W2 12'h2AA
`define NFH_A_B1 12'hAAA
`define NFH_A_B2 12'h555

// host operation codes on op_code
`define NFH_OP_READ 4'h0
`define NFH_OP_PROGRAM 4'h1
`define NFH_OP_AUTOSEL 4'h2
`define NFH_OP_RESET 4'h3
`define NFH_OP_BYPASS 4'h4
`define NFH_OP_BYP_PROG 4'h5
`define NFH_OP_BYP_EXIT 4'h6
`define NFH_OP_SUSPEND 4'h7
`define NFH_OP_RESUME 4'h8
`define NFH_OP_QUERY 4'h9

// widths
`define NFH_AW 20
`define NFH_DW 16

`endif

// [nfh_cycle.v]
/*
 * one bus cycle engine: performs a single write or read cycle on the flash
 * pins. assumes the caller holds addr/data/mode stable while busy is high.
 */
`include "nfh_map.vh"

module nfh_cycle (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	// request
	input wire start,
	input wire is_write,
	input wire [`NFH_AW-1:0] addr,
	input wire [`NFH_DW-1:0] wdata,
	input wire byte_mode,
	// flash pins
	output reg ce_n_q,
	output reg oe_n_q,
	output reg we_n_q,
	output reg [`NFH_AW-1:0] a_q,
	output reg [`NFH_DW-1:0] dq_o_q,
	output reg dq_oe_n_q,
	output reg a_lsb_q,
	input wire [`NFH_DW-1:0] dq_sync,
	// result
	output reg busy_q,
	output reg done_q,
	output reg [`NFH_DW-1:0] rdata_q
);
	localparam PH_IDLE = 2'd0;
	localparam PH_SET = 2'd1;
	localparam PH_STROBE = 2'd2;
	localparam PH_HOLD = 2'd3;
	localparam integer WP_I = `NFH_WP_CYC;
	localparam integer RD_I = `NFH_ACC_CYC + 1;
	localparam integer WH_I = `NFH_WH_CYC;
	// counts cut to the counter's width; every one fits in four bits
	localparam [3:0] WP_CNT = WP_I[3:0];
	localparam [3:0] RD_CNT = RD_I[3:0];
	localparam [3:0] WH_CNT = WH_I[3:0];

	reg [1:0] ph_q;
	reg [3:0] cnt_q;
	reg wr_q;

	// address on pins before strobes fall, data held until after they rise
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ph_q <= PH_IDLE;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			a_q <= {`NFH_AW{1'b0}};
			dq_o_q <= {`NFH_DW{1'b0}};
			dq_oe_n_q <= 1'b1;
			a_lsb_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= {`NFH_DW{1'b0}};
		end else if (clk_en) begin
			done_q <= 1'b0;
			case (ph_q)
			PH_IDLE: begin
				if (start) begin
					busy_q <= 1'b1;
					wr_q <= is_write;
					// byte mode: byte address split into word lines and the lsb line
					a_q <= byte_mode ? {1'b0, addr[`NFH_AW-1:1]} : addr;
					a_lsb_q <= byte_mode & addr[0];
					// byte mode: upper lines driven as zero
					dq_o_q <= byte_mode ? {8'h00, wdata[7:0]} : wdata;
					dq_oe_n_q <= ~is_write;
					ph_q <= PH_SET;
				end
			end
			PH_SET: begin
				// ce and we low together with oe high forms a write
				ce_n_q <= 1'b0;
				we_n_q <= ~wr_q;
				oe_n_q <= wr_q;
				cnt_q <= wr_q ? WP_CNT : RD_CNT;
				ph_q <= PH_STROBE;
			end
			PH_STROBE: begin
				if (cnt_q > 4'h1) begin
					cnt_q <= cnt_q - 4'h1;
				end else begin
					// we, ce and oe rise together; data stays on pins through the hold
					we_n_q <= 1'b1;
					ce_n_q <= 1'b1;
					oe_n_q <= 1'b1;
					if (!wr_q) begin
						rdata_q <= byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync;
					end
					cnt_q <= WH_CNT;
					ph_q <= PH_HOLD;
				end
			end
			PH_HOLD: begin
				if (cnt_q > 4'h1) begin
					cnt_q <= cnt_q - 4'h1;
				end else begin
					dq_oe_n_q <= 1'b1;
					busy_q <= 1'b0;
					done_q <= 1'b1;
					ph_q <= PH_IDLE;
				end
			end
			default: ph_q <= PH_IDLE;
			endcase
		end
	end
endmodule // nfh_cycle

// [nfh_host.v]
/*
 * host controller for a dual bank parallel nor flash: turns single operation
 * requests into the flash's command bus sequences and reads back results.
 * assumes flash pins are joined by the bench; dq is split into in/out/enable.
 */
// Summary of operation
// - reset command F0 ends autoselect mode
// - same bank address on cycles three, four
// - autoselect entry: two unlocks then 90
// - write: ce, we low, oe high
// - program: two unlocks, setup, target data
// - no hardware reset during program
// - bypass entry: two unlocks then 20
// - bypass program: A0 then target data
// - bypass exit: 90 then 00
`include "nfh_map.vh"

module nfh_host (
	// clock, reset, enable
	input wire ref_clk,
	input wire resetn,
	input wire clk_en,
	// request port
	input wire op_valid,
	input wire [3:0] op_code,
	input wire [`NFH_AW-1:0] op_addr,
	input wire [`NFH_DW-1:0] op_data,
	input wire byte_mode,
	output reg op_ready_q,
	output reg rd_valid_q,
	output reg [`NFH_DW-1:0] rd_data_q,
	output reg bypass_q,
	output reg autosel_q,
	// flash pins
	output reg flash_ce_n_q,
	output reg flash_oe_n_q,
	output reg flash_we_n_q,
	output reg flash_byte_n_q,
	output reg [`NFH_AW-1:0] flash_a_q,
	output reg flash_a_lsb_q,
	output reg [`NFH_DW-1:0] flash_dq_o_q,
	output reg flash_dq_oe_n_q,
	input wire [`NFH_DW-1:0] flash_dq_i
);
	localparam ST_IDLE = 2'd0;
	localparam ST_ISSUE = 2'd1;
	localparam ST_WAIT = 2'd2;

	reg [1:0] st_q;
	reg [3:0] op_q;
	reg [`NFH_AW-1:0] adr_q;
	reg [`NFH_DW-1:0] dat_q;
	reg [2:0] step_q;
	reg [2:0] nsteps;
	reg start_q;
	reg c_wr;
	reg [`NFH_AW-1:0] c_addr;
	reg [7:0] c_cmd;
	reg [`NFH_DW-1:0] c_data;
	reg [`NFH_DW-1:0] s1_q, s2_q, s3_q, dq_hold_q;
	wire [`NFH_DW-1:0] dq_stable;
	wire ce_n, oe_n, we_n, a_lsb, dq_oe_n, busy, done;
	wire [`NFH_AW-1:0] a_pin;
	wire [`NFH_DW-1:0] dq_o, rdata;
	wire [11:0] ua1, ua2;
	wire [`NFH_AW-1:0] bank_sel;

	// three stage input sampling, second and third must agree
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= {`NFH_DW{1'b0}};
			s2_q <= {`NFH_DW{1'b0}};
			s3_q <= {`NFH_DW{1'b0}};
			dq_hold_q <= {`NFH_DW{1'b0}};
		end else if (clk_en) begin
			s1_q <= flash_dq_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			dq_hold_q <= dq_stable;
		end
	end
	// a half-settled bus word is never taken: old value kept until stages agree
	assign dq_stable = (s2_q == s3_q) ? s3_q : dq_hold_q;

	// unlock addresses by width
	assign ua1 = byte_mode ? `NFH_A_B1 : `NFH_A_W1;
	assign ua2 = byte_mode ? `NFH_A_B2 : `NFH_A_W2;
	// bank bits kept, low bits replaced, same on third and fourth
	assign bank_sel = {adr_q[`NFH_AW-1:12], 12'h000};

	// sequence tables: count of bus cycles per operation
	always @* begin
		case (op_q)
		`NFH_OP_READ: nsteps = 3'd1;
		`NFH_OP_PROGRAM: nsteps = 3'd4;
		`NFH_OP_AUTOSEL: nsteps = 3'd4;
		`NFH_OP_RESET: nsteps = 3'd1;
		`NFH_OP_BYPASS: nsteps = 3'd3;
		`NFH_OP_BYP_PROG: nsteps = 3'd2;
		`NFH_OP_BYP_EXIT: nsteps = 3'd2;
		default: nsteps = 3'd1;
		endcase
	end

	// per step address and command byte; upper data left zero on command cycles
	always @* begin
		c_wr = 1'b1;
		c_addr = {8'h00, ua1};
		c_cmd = `NFH_D_UNLOCK1;
		c_data = {`NFH_DW{1'b0}};
		case (op_q)
		`NFH_OP_READ: begin
			// in autoselect the read returns protect or id codes
			c_wr = 1'b0;
			c_addr = adr_q;
		end
		`NFH_OP_RESET: c_cmd = `NFH_D_RESET;
		`NFH_OP_SUSPEND: c_cmd = `NFH_D_SUSPEND;
		`NFH_OP_RESUME: c_cmd = `NFH_D_RESUME;
		`NFH_OP_QUERY: begin
			c_addr = byte_mode ? 20'h000AA : 20'h00055;
			c_cmd = `NFH_D_QUERY;
		end
		`NFH_OP_BYP_PROG: begin
			if (step_q == 3'd0) begin
				c_cmd = `NFH_D_PROGRAM;
			end else begin
				c_addr = adr_q;
				c_cmd = 8'h00;
				c_data = dat_q;
			end
		end
		`NFH_OP_BYP_EXIT: c_cmd = (step_q == 3'd0) ? `NFH_D_AUTOSEL : `NFH_D_BYP_EXIT;
		default: begin
			// unlock pair, then the op's own third and fourth cycles
			case (step_q)
			3'd0: c_cmd = `NFH_D_UNLOCK1;
			3'd1: begin
				c_addr = {8'h00, ua2};
				c_cmd = `NFH_D_UNLOCK2;
			end
			3'd2: begin
				if (op_q == `NFH_OP_AUTOSEL) begin
					c_addr = bank_sel | {8'h00, ua1};
					c_cmd = `NFH_D_AUTOSEL;
				end else if (op_q == `NFH_OP_BYPASS) begin
					c_cmd = `NFH_D_BYPASS;
				end else begin
					c_cmd = `NFH_D_PROGRAM;
				end
			end
			default: begin
				if (op_q == `NFH_OP_AUTOSEL) begin
					c_wr = 1'b0;
					c_addr = bank_sel | {12'h000, adr_q[7:0]};
				end else begin
					c_addr = adr_q;
					c_cmd = 8'h00;
					c_data = dat_q;
				end
			end
			endcase
		end
		endcase
		if (c_wr && c_cmd != 8'h00) begin
			c_data = {8'h00, c_cmd};
		end
	end

	nfh_cycle u_cycle (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.start(start_q),
		.is_write(c_wr),
		.addr(c_addr),
		.wdata(c_data),
		.byte_mode(byte_mode),
		.ce_n_q(ce_n),
		.oe_n_q(oe_n),
		.we_n_q(we_n),
		.a_q(a_pin),
		.dq_o_q(dq_o),
		.dq_oe_n_q(dq_oe_n),
		.a_lsb_q(a_lsb),
		.dq_sync(dq_stable),
		.busy_q(busy),
		.done_q(done),
		.rdata_q(rdata)
	);

	// pin outputs re-registered; ce idles high for standby; no flash reset driven
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			flash_ce_n_q <= 1'b1;
			flash_oe_n_q <= 1'b1;
			flash_we_n_q <= 1'b1;
			flash_byte_n_q <= 1'b1;
			flash_a_q <= {`NFH_AW{1'b0}};
			flash_a_lsb_q <= 1'b0;
			flash_dq_o_q <= {`NFH_DW{1'b0}};
			flash_dq_oe_n_q <= 1'b1;
		end else if (clk_en) begin
			flash_ce_n_q <= ce_n;
			flash_oe_n_q <= oe_n;
			flash_we_n_q <= we_n;
			flash_byte_n_q <= ~byte_mode;
			flash_a_q <= a_pin;
			flash_a_lsb_q <= a_lsb;
			flash_dq_o_q <= dq_o;
			flash_dq_oe_n_q <= dq_oe_n;
		end
	end

	// sequencer: one request at a time, device may sleep between them
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= ST_IDLE;
			op_q <= `NFH_OP_READ;
			adr_q <= {`NFH_AW{1'b0}};
			dat_q <= {`NFH_DW{1'b0}};
			step_q <= 3'd0;
			start_q <= 1'b0;
			op_ready_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q <= {`NFH_DW{1'b0}};
			bypass_q <= 1'b0;
			autosel_q <= 1'b0;
		end else if (clk_en) begin
			start_q <= 1'b0;
			rd_valid_q <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				op_ready_q <= 1'b1;
				if (op_valid && op_ready_q) begin
					op_ready_q <= 1'b0;
					op_q <= op_code;
					adr_q <= op_addr;
					dat_q <= op_data;
					step_q <= 3'd0;
					st_q <= ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				// engine must be back in idle before the next cycle starts
				start_q <= ~busy;
				st_q <= busy ? ST_ISSUE : ST_WAIT;
			end
			ST_WAIT: begin
				if (done) begin
					if (step_q + 3'd1 < nsteps) begin
						step_q <= step_q + 3'd1;
						st_q <= ST_ISSUE;
					end else begin
						if (op_q == `NFH_OP_READ || op_q == `NFH_OP_AUTOSEL) begin
							rd_data_q <= rdata;
							rd_valid_q <= 1'b1;
						end
						// mode tracking mirrors the device's command state
						case (op_q)
						`NFH_OP_AUTOSEL: autosel_q <= 1'b1;
						`NFH_OP_RESET: autosel_q <= 1'b0;
						`NFH_OP_BYPASS: bypass_q <= 1'b1;
						`NFH_OP_BYP_EXIT: bypass_q <= 1'b0;
						default: autosel_q <= autosel_q;
						endcase
						st_q <= ST_IDLE;
					end
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // nfh_host

// [nfh_host_asserts.sv]
/* checker for the nor flash host pin timing.
   assumes clk_en held high and byte_mode changed only while idle. */
`include "nfh_map.vh"
module nfh_chk (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// host side
	input wire byte_mode,
	input wire op_ready_q,
	input wire rd_valid_q,
	// flash pins
	input wire flash_ce_n_q,
	input wire flash_oe_n_q,
	input wire flash_we_n_q,
	input wire flash_byte_n_q,
	input wire [`NFH_AW-1:0] flash_a_q,
	input wire [`NFH_DW-1:0] flash_dq_o_q,
	input wire flash_dq_oe_n_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	AST_WR_STROBES: assert property (!flash_we_n_q |-> !flash_ce_n_q && flash_oe_n_q)
		else $error("write strobe without ce low and oe high");
	AST_WR_HOLD: assert property (!flash_we_n_q && !$past(flash_we_n_q)
		|-> $stable(flash_a_q) && $stable(flash_dq_o_q)) else $error("write fields moved");
	AST_WE_LEN: assert property ($fell(flash_we_n_q) |-> ##1 !flash_we_n_q ##1 flash_we_n_q)
		else $error("write pulse not two clocks");
	AST_DATA_HOLD: assert property ($rose(flash_we_n_q)
		|-> !flash_dq_oe_n_q && $stable(flash_dq_o_q)) else $error("data not held");
	AST_RD_NODRV: assert property (!flash_oe_n_q
		|-> flash_dq_oe_n_q && flash_we_n_q && !flash_ce_n_q) else $error("read contention");
	AST_RD_LEN: assert property ($fell(flash_oe_n_q) |-> !flash_oe_n_q[*5] ##1 flash_oe_n_q)
		else $error("read strobe not five clocks");
	AST_RDV_PULSE: assert property (rd_valid_q |=> !rd_valid_q)
		else $error("read valid longer than one clock");
	AST_IDLE_STANDBY: assert property (op_ready_q |-> flash_ce_n_q && flash_dq_oe_n_q)
		else $error("idle without standby");
	AST_BYTE_PIN: assert property (!flash_ce_n_q |-> flash_byte_n_q == !byte_mode)
		else $error("byte pin disagrees with mode");
endmodule // nfh_chk
bind nfh_host nfh_chk u_chk (.ref_clk, .resetn, .byte_mode, .op_ready_q, .rd_valid_q,
	.flash_ce_n_q, .flash_oe_n_q, .flash_we_n_q, .flash_byte_n_q, .flash_a_q,
	.flash_dq_o_q, .flash_dq_oe_n_q);

// [nfh_flash_model.sv]
/* behavioural model of the dual bank nor flash command interface.
   assumes word-address unlock cycles; dq_out is only meaningful when read. */
module nfh_flash_model #(
	parameter [15:0] MFR_CODE = 16'h005A, // arbitrary value
	parameter [15:0] DEV_CODE = 16'h1234, // arbitrary value
	parameter [7:0] PROT_BLK = 8'h01,
	parameter PROG_NS = 30
) (
	// strobes
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire byte_n,
	// address and data
	input wire [19:0] a,
	input wire a_lsb,
	input wire [15:0] dq_in,
	output logic [15:0] dq_out = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [logic [19:0]];
	logic [19:0] a_l;
	logic lsb_l;
	logic wr = 0;
	logic busy = 0;
	logic [1:0] mode_q = 0; // 0 read, 1 autoselect, 2 bypass
	int cyc = 0;
	function automatic logic [15:0] look();
		logic [15:0] w;
		w = mem.exists(a) ? mem[a] : 16'hFFFF;
		if (mode_q == 1)
			case (a[1:0]) // code picked by selector bits and bank only
			0: w = MFR_CODE;
			1: w = DEV_CODE;
			2: w = {15'h0, a[19:12] == PROT_BLK};
			default: w = 16'h0080; // security region locked
			endcase
		return w;
	endfunction
	task automatic prog(input logic [15:0] d);
		if (!byte_n)
			d = lsb_l ? {d[7:0], 8'hFF} : {8'hFF, d[7:0]};
		mem[a_l] = (mem.exists(a_l) ? mem[a_l] : 16'hFFFF) & d; // bits only cleared
		busy = 1;
		busy <= #(PROG_NS) 0;
	endtask
	task automatic cmd(input logic [15:0] d);
		logic [7:0] c;
		c = d[7:0]; // upper data ignored; address checked on unlock cycles
		if (busy)
			return;
		if (c == 8'hF0 && mode_q != 2) begin
			mode_q = 0;
			cyc = 0;
		end else if (mode_q == 2) begin
			if (cyc == 1)
				prog(d);
			if (cyc == 2 && c == 8'h00)
				mode_q = 0;
			cyc = (cyc == 0 && c == 8'hA0) ? 1 : (cyc == 0 && c == 8'h90) ? 2 : 0;
		end else
			case (cyc)
			0: cyc = (a_l[10:0] == 11'h555 && c == 8'hAA) ? 1 : 0;
			1: cyc = (a_l[10:0] == 11'h2AA && c == 8'h55) ? 2 : 0;
			2: begin
				if (c == 8'h90)
					mode_q = 1;
				if (c == 8'h20)
					mode_q = 2;
				cyc = (c == 8'hA0) ? 3 : 0;
			end
			default: begin
				prog(d);
				cyc = 0;
			end
			endcase
	endtask
	// address on the later falling strobe
	always @(negedge we_n or negedge ce_n)
		if (!we_n && !ce_n && oe_n) begin
			a_l = a;
			lsb_l = a_lsb;
			wr = 1;
		end
	// data on the earlier rising strobe
	always @(posedge we_n or posedge ce_n)
		if (wr) begin
			wr = 0;
			cmd(dq_in);
		end
	// valid only when selected and read; otherwise the last value inverted, no stale value
	always @(ce_n or oe_n or we_n or a or a_lsb or byte_n)
		if (!ce_n && !oe_n && we_n)
			dq_out = byte_n ? look() : {~dq_out[15:8], 8'(a_lsb ? look() >> 8 : look())};
		else
			dq_out = ~dq_out;
endmodule // nfh_flash_model

// [nfh_host_tb_top.sv]
/* self-checking bench for the nor flash host controller.
   assumes op_addr is a byte address in byte mode. */
`include "nfh_map.vh"
module nfh_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [15:0] MFR = 16'h005A; // arbitrary value
	localparam [15:0] DEV = 16'h1234; // arbitrary value
	logic ref_clk = 0, resetn = 0, op_valid = 0, byte_mode = 0;
	logic [3:0] op_code = 0;
	logic [19:0] op_addr = 0, ad;
	logic [15:0] op_data = 0, got, d;
	logic [31:0] seed = 32'hBB9C3104;
	logic [15:0] ref_mem [logic [19:0]];
	int mismatches = 0, comparisons = 0, i;
	wire op_ready_q, rd_valid_q, bypass_q, autosel_q, ce_n, oe_n, we_n, byte_n, lsb, dq_oe_n;
	wire [19:0] a;
	wire [15:0] rd_data, dq_o, dq_mod, dq_i;
	always #10 ref_clk = ~ref_clk;
	// wire level: host wins only while it enables its drivers
	assign dq_i = !dq_oe_n ? dq_o : dq_mod;
	nfh_host dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .op_valid(op_valid),
		.op_code(op_code), .op_addr(op_addr), .op_data(op_data), .byte_mode(byte_mode),
		.op_ready_q(op_ready_q), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data),
		.bypass_q(bypass_q), .autosel_q(autosel_q), .flash_ce_n_q(ce_n), .flash_oe_n_q(oe_n),
		.flash_we_n_q(we_n), .flash_byte_n_q(byte_n), .flash_a_q(a), .flash_a_lsb_q(lsb),
		.flash_dq_o_q(dq_o), .flash_dq_oe_n_q(dq_oe_n), .flash_dq_i(dq_i));
	nfh_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .byte_n(byte_n), .a(a), .a_lsb(lsb), .dq_in(dq_i), .dq_out(dq_mod));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] ref_rd(input logic [19:0] x);
		return ref_mem.exists(x) ? ref_mem[x] : 16'hFFFF;
	endfunction
	function automatic logic [15:0] auto_exp(input logic [19:0] x);
		case (x[1:0])
		0: return MFR;
		1: return DEV;
		2: return {15'h0, x[19:12] == 8'h01};
		default: return 16'h0080;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one request: held until taken, then wait for ready with a bound
	task automatic op(input logic [3:0] c, input logic [19:0] x, input logic [15:0] v);
		int n;
		n = 0;
		got = 16'hXXXX;
		@(negedge ref_clk);
		op_valid = 1;
		op_code = c;
		op_addr = x;
		op_data = v;
		while (op_ready_q !== 1'b1 && n++ < 400)
			@(negedge ref_clk);
		@(negedge ref_clk);
		op_valid = 0;
		while (op_ready_q !== 1'b1 && n++ < 400) begin
			if (rd_valid_q === 1'b1)
				got = rd_data;
			@(negedge ref_clk);
		end
		if (n >= 400)
			chk("op_ready_q", 16'h0001, 16'h0000);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#(20 * 30000);
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		resetn = 1;
		op(0, 20'h00100, 0);
		chk("erased read", 16'hFFFF, got);
		for (i = 0; i < 12; i++) begin
			ad = 20'h10 + (xs() & 7);
			d = xs();
			op(1, ad, d);
			ref_mem[ad] = ref_rd(ad) & d;
			op(0, ad, 0);
			chk("program", ref_rd(ad), got);
		end
		$display("test program done");
		for (i = 0; i < 8; i++) begin
			ad = {i < 4 ? 8'h01 : 8'h02, 10'h0, i[1:0]};
			op(2, ad, 0);
			chk("autoselect", auto_exp(ad), got);
			chk("autosel_q", 16'h0001, {15'h0, autosel_q});
		end
		op(0, 20'h01001, 0);
		chk("still autoselect", DEV, got);
		op(3, 0, 0);
		op(0, ad, 0);
		chk("after reset", ref_rd(ad), got);
		$display("test autoselect done");
		op(4, 0, 0);
		chk("bypass_q", 16'h0001, {15'h0, bypass_q});
		for (i = 0; i < 4; i++) begin
			d = xs();
			op(5, 20'h20 + i, d);
			ref_mem[20'h20 + i] = ref_rd(20'h20 + i) & d;
		end
		op(6, 0, 0);
		chk("bypass exit", 16'h0000, {15'h0, bypass_q});
		op(7, 0, 0);
		op(8, 0, 0);
		op(9, 0, 0);
		op(4'hF, 0, 0);
		op(3, 0, 0);
		for (i = 0; i < 4; i++) begin
			op(0, 20'h20 + i, 0);
			chk("bypass program", ref_rd(20'h20 + i), got);
		end
		$display("test bypass done");
		@(negedge ref_clk);
		byte_mode = 1;
		op(0, 20'h41, 0);
		chk("byte high", ref_rd(20'h20) >> 8, got);
		op(0, 20'h40, 0);
		chk("byte low", ref_rd(20'h20) & 16'h00FF, got);
		@(negedge ref_clk);
		byte_mode = 0;
		$display("test byte mode done");
		wrap_up();
	end
endmodule // nfh_host_tb_top
